// >>> hw/test_point_port.sv
`timescale 1ns/1ns
// What this block does
// R1 - pins stay inputs while reset held
// R2 - after release pins drive selected mode
// R3 - capture strap at release, hold until reset
// R4 - sample only on reset rising edge
// R5 - pulldowns make unstrapped strap all zeros
// R6 - mode 000 keeps all pins tri-stated
// R7 - mode 010 drives clocks and fixed levels
// R8 - software may reselect outputs any time; writes in reset or in the strap capture cycle are ignored
// R9 - board pulls low bits high to select
// R10 - board leaves upper five pins unstrapped
module test_point_port
	import tp_pkg::*;
(
	// clock, enable and active low system reset
	input wire logic clk,
	input wire logic ce,
	input wire logic active_low_system_reset_n,
	// test point pins, three signal form plus pulldown enable
	input wire logic [tp_width-1:0] test_point_pins_in,
	output logic [tp_width-1:0] test_point_pins_out,
	output logic [tp_width-1:0] test_point_pins_oe,
	output logic [tp_width-1:0] test_point_pins_pd_en,
	// software output reselection
	input wire tp_pkg::sw_sel_s sw_sel,
	// captured mode, visible to the core
	output logic [mode_width-1:0] mode_r
);
	import tp_pkg::*;
	logic rst_n;
	logic [tp_width-1:0] pin_s1_r, pin_s2_r;
	logic held_r, run_r;
	logic [tp_width*sel_width-1:0] sel_r;
	logic [7:0] var_half_r;
	logic [div_width-1:0] div_q;
	logic var_clk;
	tp_drive_s drv_nxt;
	assign rst_n = active_low_system_reset_n;

	function automatic logic [tp_width*sel_width-1:0] mode_sel(
		input logic [2:0] m);
		if (m == mode_clk_debug) begin
			mode_sel = {sel_div16, sel_high, sel_high, sel_low,
				sel_high, sel_var, sel_div4, sel_div2}; // [R7]
		end else begin
			mode_sel = sel_reset; // [R6]
		end
	endfunction : mode_sel

	// pin levels are from outside, two stages before use
	always_ff @(posedge clk) begin
		if (ce) begin
			pin_s1_r <= test_point_pins_in;
			pin_s2_r <= pin_s1_r;
		end
	end

	// held_r marks reset seen; first cycle after release catches strap
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			held_r <= 1'b1;
			run_r <= 1'b0;
			mode_r <= mode_quiet;
		end else if (ce) begin
			if (held_r) begin
				mode_r <= pin_s2_r[mode_width-1:0]; // [R3] [R4] [R5]
				held_r <= 1'b0;
				run_r <= 1'b1; // [R2]
			end
		end
	end

	// strap defaults load at release, software may overwrite later
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			sel_r <= sel_reset;
			var_half_r <= var_half_reset;
		end else if (ce) begin
			if (held_r) begin
				sel_r <= mode_sel(pin_s2_r[mode_width-1:0]);
			end else if (sw_sel.wr) begin
				sel_r <= sw_sel.sel; // [R8]
				var_half_r <= (sw_sel.var_half < var_half_min) ?
					var_half_min : sw_sel.var_half;
			end
		end
	end

	tp_clkgen u_clkgen (
		.clk(clk),
		.rst_n(rst_n),
		.ce(ce),
		.run(run_r),
		.var_half(var_half_r),
		.div_q(div_q),
		.var_clk(var_clk)
	);

	// derived clocks from 100 MHz clk; 60 MHz needs a faster source
	always_comb begin
		drv_nxt.out = '0;
		drv_nxt.oe = '0;
		for (int i = 0; i < tp_width; i++) begin
			case (sel_r[i*sel_width +: sel_width])
				sel_hiz: drv_nxt.oe[i] = 1'b0;
				sel_low: begin
					drv_nxt.oe[i] = 1'b1;
					drv_nxt.out[i] = 1'b0;
				end
				sel_high: begin
					drv_nxt.oe[i] = 1'b1;
					drv_nxt.out[i] = 1'b1;
				end
				sel_div2: begin
					drv_nxt.oe[i] = 1'b1;
					drv_nxt.out[i] = div_q[0];
				end
				sel_div4: begin
					drv_nxt.oe[i] = 1'b1;
					drv_nxt.out[i] = div_q[1];
				end
				sel_var: begin
					drv_nxt.oe[i] = 1'b1;
					drv_nxt.out[i] = var_clk;
				end
				sel_div16: begin
					drv_nxt.oe[i] = 1'b1;
					drv_nxt.out[i] = div_q[3];
				end
				default: drv_nxt.oe[i] = 1'b0;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			test_point_pins_out <= '0;
			test_point_pins_oe <= '0; // [R1]
			test_point_pins_pd_en <= '1; // [R5]
		end else if (ce) begin
			test_point_pins_out <= drv_nxt.out;
			test_point_pins_oe <= run_r ? drv_nxt.oe : '0; // [R2]
			test_point_pins_pd_en <= '1;
		end
	end

	a_inputs_in_reset: assert property (@(posedge clk)
		!rst_n |=> test_point_pins_oe == '0) // [R1]
		else $error("pins driven during reset");
	a_mode_held: assert property (@(posedge clk) disable iff (!rst_n)
		!held_r |=> $stable(mode_r)) // [R4]
		else $error("mode changed without reset");
	sequence rel_s;
		!rst_n ##1 rst_n && ce;
	endsequence
	a_strap_capture: assert property (@(posedge clk)
		rel_s |=> mode_r == $past(pin_s2_r[2:0], 1)) // [R3]
		else $error("strap not captured at release");
	// a later software write may legally drive pins, so key on sel_r
	a_quiet_hiz: assert property (@(posedge clk) disable iff (!rst_n) // [R6]
		(ce && mode_r == mode_quiet && sel_r == mode_sel(mode_quiet))
		|=> test_point_pins_oe == '0)
		else $error("quiet mode drove a pin");
	a_debug_levels: assert property (@(posedge clk) disable iff (!rst_n)
		(ce && sel_r == mode_sel(mode_clk_debug) && run_r) |=>
		test_point_pins_oe == '1 && test_point_pins_out[6:3] == 4'hd)
		// [R7]
		else $error("debug fixed levels wrong");
	a_sw_reselect: assert property (@(posedge clk) disable iff (!rst_n)
		(ce && sw_sel.wr && !held_r) |=> sel_r == $past(sw_sel.sel)) // [R8]
		else $error("software selection not taken");
	a_pulldown_on: assert property (@(posedge clk) disable iff (!rst_n)
		##1 test_point_pins_pd_en == '1) // [R5]
		else $error("pulldown released");
	a_drive_after: assert property (@(posedge clk) disable iff (!rst_n) // [R2]
		(rel_s ##1 ce) |=> test_point_pins_oe == $past(drv_nxt.oe))
		else $error("pins not driven after release");
	a_out_in_reset: assert property (@(posedge clk) // [R1]
		!rst_n |=> test_point_pins_out == '0)
		else $error("pin levels not cleared in reset");
	a_pd_in_reset: assert property (@(posedge clk) // [R5]
		!rst_n |=> test_point_pins_pd_en == '1)
		else $error("pulldown off in reset");
	a_default_sel: assert property (@(posedge clk) // [R3]
		rel_s |=> sel_r == mode_sel($past(pin_s2_r[2:0])))
		else $error("strap defaults not loaded");
	// unknown strap codes fall back to the quiet selection
	a_other_codes: assert property (@(posedge clk) disable iff (!rst_n) // [R6]
		(ce && held_r && pin_s2_r[2:0] != mode_clk_debug)
		|=> sel_r == sel_reset)
		else $error("unknown strap code drove a pin");
	a_run_set: assert property (@(posedge clk) disable iff (!rst_n) // [R2]
		(ce && held_r) |=> run_r && !held_r)
		else $error("port not running after capture");
	sequence div2_s;
		ce && run_r && sel_r[2:0] == sel_div2;
	endsequence
	a_half_rate: assert property (@(posedge clk) disable iff (!rst_n) // [R7]
		(div2_s ##1 div2_s) |=>
		test_point_pins_out[0] != $past(test_point_pins_out[0]))
		else $error("half rate pin not toggling");
	a_fixed_low: assert property (@(posedge clk) disable iff (!rst_n) // [R7]
		(ce && run_r && sel_r[14:12] == sel_low)
		|=> test_point_pins_oe[4] && !test_point_pins_out[4])
		else $error("low level pin wrong");
	a_hiz_pin: assert property (@(posedge clk) disable iff (!rst_n) // [R6]
		(ce && sel_r[23:21] == sel_hiz) |=> !test_point_pins_oe[7])
		else $error("tri-stated pin driven");
endmodule : test_point_port

// >>> hw/tp_clkgen.sv
`timescale 1ns/1ns
module tp_clkgen
	import tp_pkg::*;
(
	// clock and control
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic run,
	// variable clock half period
	input wire logic [7:0] var_half,
	// derived clocks
	output logic [div_width-1:0] div_q,
	output logic var_clk
);
	logic [7:0] var_cnt_r;
	// counters stay parked while the port is held in reset
	always_ff @(posedge clk) begin
		if (!rst_n || !run) begin
			div_q <= '0;
		end else if (ce) begin
			div_q <= div_q + 1'b1;
		end
	end
	always_ff @(posedge clk) begin
		if (!rst_n || !run) begin
			var_cnt_r <= '0;
			var_clk <= 1'b0;
		end else if (ce) begin
			if (var_cnt_r + 8'h01 >= var_half) begin
				var_cnt_r <= '0;
				var_clk <= ~var_clk;
			end else begin
				var_cnt_r <= var_cnt_r + 8'h01;
			end
		end
	end
endmodule : tp_clkgen

// >>> inc/tp_pkg.sv
package tp_pkg;
	localparam int tp_width = 8;
	localparam int mode_width = 3;
	// strap codes on the low three pins
	localparam logic [2:0] mode_quiet = 3'h0;
	localparam logic [2:0] mode_clk_debug = 3'h2;
	// output selection codes, one per pin
	localparam int sel_width = 3;
	localparam logic [2:0] sel_hiz = 3'h0;
	localparam logic [2:0] sel_low = 3'h1;
	localparam logic [2:0] sel_high = 3'h2;
	localparam logic [2:0] sel_div2 = 3'h3;
	localparam logic [2:0] sel_div4 = 3'h4;
	localparam logic [2:0] sel_var = 3'h5;
	localparam logic [2:0] sel_div16 = 3'h6;
	// a 120 MHz reference would be needed for exact rates; our clk is 100 MHz
	localparam int clk_mhz = 100;
	localparam int div_width = 4;
	// variable clock divisor range, in clk cycles per half period
	localparam logic [7:0] var_half_min = 8'h02;
	localparam logic [7:0] var_half_reset = 8'h02;
	localparam logic [23:0] sel_reset = 24'h0;
	typedef struct packed {
		logic [tp_width-1:0] out;
		logic [tp_width-1:0] oe;
	} tp_drive_s;
	typedef struct packed {
		logic wr;
		logic [tp_width*sel_width-1:0] sel;
		logic [7:0] var_half;
	} sw_sel_s;
endpackage : tp_pkg

// >>> testbench/test_point_strap_debug_port_test.sv
`timescale 1ns/1ns
`define check(nm, e, g) begin checks_done++; if ((g) !== (e)) begin \
	n_errors++; $display("Error %s expected %h seen %h", nm, e, g); end end
module test_point_strap_debug_port_test;
	import tp_pkg::*;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [2:0] strap = 3'h0;
	logic [7:0] pins, out, oe, pd;
	logic [2:0] mode;
	logic p;
	sw_sel_s sw = '0;
	int n_errors = 0;
	int checks_done = 0;
	int cycles = 0;
	always #5 clk = ~clk;
	tp_board u_board(.oe(oe), .out(out), .pd_en(pd), .strap(strap),
		.pins(pins));
	test_point_port u_dut(.clk(clk), .ce(1'b1),
		.active_low_system_reset_n(rst_n), .test_point_pins_in(pins),
		.test_point_pins_out(out), .test_point_pins_oe(oe),
		.test_point_pins_pd_en(pd), .sw_sel(sw), .mode_r(mode));
	task finish_test;
		if (n_errors == 0 && checks_done > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : finish_test
	// run should end near 50 cycles; far margin before calling it hung
	always @(posedge clk) begin
		cycles++;
		if (cycles == 3000) begin
			n_errors++;
			finish_test();
		end
	end
	task cyc(input int n);
		repeat (n) @(negedge clk);
	endtask : cyc
	// strap set well before release so the synchronisers settle
	task boot(input logic [2:0] s);
		strap = s;
		rst_n = 1'b0;
		cyc(6);
		`check("oe in reset", 8'h00, oe)
		`check("pulldowns", 8'hff, pd)
		rst_n = 1'b1;
		cyc(4);
	endtask : boot
	task clk_debug;
		boot(mode_clk_debug);
		`check("mode", 3'h2, mode)
		`check("oe live", 8'hff, oe)
		`check("fixed levels", 8'h68, out & 8'h78)
		p = out[0];
		cyc(1);
		`check("half rate", ~p, out[0])
		p = out[2];
		cyc(2);
		`check("variable clock", ~p, out[2])
		p = out[7];
		cyc(8);
		`check("sixteenth rate", ~p, out[7])
		strap = 3'h0;
		cyc(6);
		`check("late strap", 3'h2, mode)
	endtask : clk_debug
	task reselect;
		sw.sel = {8{sel_high}};
		sw.wr = 1'b1;
		cyc(1);
		sw.sel = {8{sel_hiz}};
		cyc(1);
		sw.wr = 1'b0;
		`check("all high", 8'hff, out)
		cyc(2);
		`check("all hiz", 8'h00, oe)
	endtask : reselect
	task quiet;
		boot(3'h0);
		`check("recapture", 3'h0, mode)
		// pins undriven here, so a late strap really reaches them
		strap = 3'h2;
		cyc(8);
		`check("late strap quiet", 3'h0, mode)
		`check("quiet oe", 8'h00, oe)
	endtask : quiet
	initial begin
		clk_debug();
		reselect();
		quiet();
		finish_test();
	end
endmodule : test_point_strap_debug_port_test

// >>> testbench/tp_board.sv
`timescale 1ns/1ns
module tp_board
	import tp_pkg::*;
(
	// device side of the pins
	input wire logic [tp_width-1:0] oe,
	input wire logic [tp_width-1:0] out,
	input wire logic [tp_width-1:0] pd_en,
	// jumpers, low three pins only
	input wire logic [mode_width-1:0] strap,
	// resolved wire
	output logic [tp_width-1:0] pins
);
	// undriven, unpulled wire shows inverse of the current out level, not a free 0
	always_comb begin
		for (int i = 0; i < tp_width; i++) begin
			if (oe[i])
				pins[i] = out[i];
			else if (i < mode_width && strap[i])
				pins[i] = 1'b1;
			else
				pins[i] = pd_en[i] ? 1'b0 : ~out[i];
		end
	end
endmodule : tp_board
